// *** nav_spi_pkg.sv ***
// Shared constants and types for the navigation SPI register port.
//
// Contract
// R1 - Host serial clock at most 15 MHz.
// R2 - Mode 3: idle high, sample rising edge.
// R3 - Frames shift most significant bit first.
// R4 - Read takes request frame, then data frame.
// R5 - Read data returns while next command arrives.
// R6 - Page 0 selected after start-up automatically.
// R7 - Host writes 0x8000 to return to page 0.
// R8 - Top bit 0 reads; address in upper byte.
// R9 - Low byte ignored; sixteen clocks needed.
// R10 - 0x1A00 gyro Z high, 0x1800 low.
// R11 - State word codes 0x00/0x10/0x20/0x30.
// R12 - Accel is 32-bit signed high and low.
// R13 - Latitude and longitude are 32-bit signed.
// R14 - Height is signed 16-bit, 0.1 m.
// R15 - Velocities signed 16-bit, 0.01 m/s.
// R16 - Data-ready pin high when new data loaded.
// R17 - Unmapped reads zero; read-only writes ignored.
// R18 - Word pairs read from one snapshot.
package nav_spi_pkg;
   // ****************************************************
   // Timing and framing.
   // ****************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int SCLK_MAX_HZ = 15_000_000;
   localparam int SCLK_MIN_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int WORD_W = 16;
   localparam int CNT_W = 5;
   localparam int ADDR_W = 7;
   localparam int IDX_W = 6;
   localparam int MAP_WORDS = 64;
   localparam int CMD_WR_BIT = 15;
   localparam int CMD_ADDR_HI = 14;
   localparam int CMD_ADDR_LO = 8;
   localparam int CMD_DATA_HI = 7;
   localparam logic [2:0] PIN_RESET = 3'h6;
   // ****************************************************
   // Register map, byte addresses on page zero.
   // ****************************************************
   localparam logic [6:0] ADDR_PAGE_SEL = 7'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [6:0] OFF_TEMP = 7'h0e;
   localparam logic [6:0] OFF_GYRO_X_LO = 7'h10;
   localparam logic [6:0] OFF_GYRO_X_HI = 7'h12;
   localparam logic [6:0] OFF_GYRO_Y_LO = 7'h14;
   localparam logic [6:0] OFF_GYRO_Y_HI = 7'h16;
   localparam logic [6:0] OFF_GYRO_Z_LO = 7'h18;
   localparam logic [6:0] OFF_GYRO_Z_HI = 7'h1a;
   localparam logic [6:0] OFF_ACC_X_LO = 7'h1c;
   localparam logic [6:0] OFF_ACC_X_HI = 7'h1e;
   localparam logic [6:0] OFF_ACC_Y_LO = 7'h20;
   localparam logic [6:0] OFF_ACC_Y_HI = 7'h22;
   localparam logic [6:0] OFF_ACC_Z_LO = 7'h24;
   localparam logic [6:0] OFF_ACC_Z_HI = 7'h26;
   localparam logic [6:0] OFF_RSVD_LO = 7'h28;
   localparam logic [6:0] OFF_RSVD_HI = 7'h5e;
   localparam logic [6:0] OFF_HEADING = 7'h60;
   localparam logic [6:0] OFF_PITCH = 7'h62;
   localparam logic [6:0] OFF_ROLL = 7'h64;
   localparam logic [6:0] OFF_LAT_LO = 7'h66;
   localparam logic [6:0] OFF_LAT_HI = 7'h68;
   localparam logic [6:0] OFF_LON_LO = 7'h6a;
   localparam logic [6:0] OFF_LON_HI = 7'h6c;
   localparam logic [6:0] OFF_ALT = 7'h6e;
   localparam logic [6:0] OFF_VEL_E = 7'h70;
   localparam logic [6:0] OFF_VEL_N = 7'h72;
   localparam logic [6:0] OFF_VEL_U = 7'h74;
   localparam logic [6:0] OFF_STATE = 7'h76;
   localparam logic [6:0] OFF_PRODUCT_IDENTITY = 7'h7e;
   // ****************************************************
   // Working-state codes and types.
   // ****************************************************
   localparam logic [15:0] STATE_STANDBY = 16'h0000;
   localparam logic [15:0] STATE_COARSE = 16'h0010;
   localparam logic [15:0] STATE_FINE = 16'h0020;
   localparam logic [15:0] STATE_NAV = 16'h0030;
   typedef enum logic [1:0] {MODE_STANDBY, MODE_COARSE, MODE_FINE, MODE_NAV} nav_mode_t;
   typedef enum logic [1:0] {LINK_IDLE = 2'b00, LINK_SHIFT = 2'b01, LINK_DECODE = 2'b11} link_state_t;
endpackage : nav_spi_pkg

// *** pin_sync.sv ***
// Two-stage pin synchroniser with edge pulses.
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] pins,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_r;
   logic [W-1:0] prev_r;

   // The first stage feeds only the second; edges compare stage two with its history.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= RESET_VAL;
         level <= RESET_VAL;
         prev_r <= RESET_VAL;
      end else begin
         meta_r <= pins;
         level <= meta_r;
         prev_r <= level;
      end
   end

   // Edge pulses last one clock.
   assign rise = level & ~prev_r;
   assign fall = ~level & prev_r;
endmodule : pin_sync

// *** shift_word.sv ***
// Loadable MSB-first shift register.
`timescale 1ns/100ps
module shift_word #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic shift,
   input wire logic sin,
   output logic [W-1:0] q
);
   // Load wins over shift; bits move toward the top so the MSB leaves first.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else if (load) begin
         q <= load_val;
      end else if (shift) begin
         q <= {q[W-2:0], sin}; // [R3]
      end
   end
endmodule : shift_word

// *** nav_spi_port.sv ***
// SPI slave register port presenting the navigation output registers.
`timescale 1ns/100ps
module nav_spi_port #(
   parameter logic [15:0] PRODUCT_IDENTITY = 16'h5a3c, // Arbitrary identity value.
   parameter int W = nav_spi_pkg::WORD_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe,
   output logic fresh_sample_pin,
   output logic [7:0] page_select_reg,
   input wire logic load_strobe,
   input wire logic [W-1:0] temp_raw,
   input wire logic [2*W-1:0] gyro_x,
   input wire logic [2*W-1:0] gyro_y,
   input wire logic [2*W-1:0] gyro_z,
   input wire logic [2*W-1:0] accel_x,
   input wire logic [2*W-1:0] accel_y,
   input wire logic [2*W-1:0] accel_z,
   input wire logic [W-1:0] heading,
   input wire logic [W-1:0] pitch,
   input wire logic [W-1:0] roll,
   input wire logic [2*W-1:0] lat,
   input wire logic [2*W-1:0] lon,
   input wire logic [W-1:0] alt,
   input wire logic [W-1:0] vel_e,
   input wire logic [W-1:0] vel_n,
   input wire logic [W-1:0] vel_u,
   input wire logic [1:0] nav_mode
);
   // ****************************************************
   // Helper functions.
   // ****************************************************

   // Word index of an even byte address.
   function automatic logic [5:0] word_idx(input logic [6:0] a);
      word_idx = a[6:1];
   endfunction : word_idx

   // True for byte addresses that hold a readable word.
   function automatic logic is_mapped(input logic [6:0] a);
      logic in_rsvd;
      in_rsvd = (a >= nav_spi_pkg::OFF_RSVD_LO) && (a <= nav_spi_pkg::OFF_RSVD_HI);
      is_mapped = !a[0] && !in_rsvd &&
                  (((a >= nav_spi_pkg::OFF_TEMP) && (a <= nav_spi_pkg::OFF_STATE)) ||
                   (a == nav_spi_pkg::OFF_PRODUCT_IDENTITY)); // [R17]
   endfunction : is_mapped

   // True for word indexes that belong to a 32-bit pair.
   function automatic logic is_pair(input logic [5:0] i);
      is_pair = ((i >= word_idx(nav_spi_pkg::OFF_GYRO_X_LO)) &&
                 (i <= word_idx(nav_spi_pkg::OFF_ACC_Z_HI))) ||
                ((i >= word_idx(nav_spi_pkg::OFF_LAT_LO)) &&
                 (i <= word_idx(nav_spi_pkg::OFF_LON_HI)));
   endfunction : is_pair

   // The other half of a pair; the two pair groups start on opposite parities.
   function automatic logic [5:0] partner(input logic [5:0] i);
      logic low_first;
      low_first = (i[0] == nav_spi_pkg::OFF_GYRO_X_LO[1]) &&
                  (i <= word_idx(nav_spi_pkg::OFF_ACC_Z_HI));
      if (i >= word_idx(nav_spi_pkg::OFF_LAT_LO)) begin
         low_first = (i[0] == nav_spi_pkg::OFF_LAT_LO[1]);
      end
      partner = low_first ? i + 6'h01 : i - 6'h01;
   endfunction : partner

   // Working-state code for each mode.
   function automatic logic [15:0] state_code(input logic [1:0] m);
      case (nav_spi_pkg::nav_mode_t'(m))
         nav_spi_pkg::MODE_STANDBY: state_code = nav_spi_pkg::STATE_STANDBY;
         nav_spi_pkg::MODE_COARSE: state_code = nav_spi_pkg::STATE_COARSE;
         nav_spi_pkg::MODE_FINE: state_code = nav_spi_pkg::STATE_FINE;
         nav_spi_pkg::MODE_NAV: state_code = nav_spi_pkg::STATE_NAV;
         default: state_code = nav_spi_pkg::STATE_STANDBY;
      endcase
   endfunction : state_code

   // ****************************************************
   // Pin synchronisation.
   // ****************************************************
   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic cs_active;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_start;
   logic frame_end;

   pin_sync #(
      .W(3),
      .RESET_VAL(nav_spi_pkg::PIN_RESET)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pins({sclk, cs_n, mosi}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Clock edges count only inside a selected frame.
   assign cs_active = !pin_lvl[1];
   assign sclk_rise = pin_rise[2] && cs_active; // [R2]
   assign sclk_fall = pin_fall[2] && cs_active; // [R2]
   assign frame_start = pin_fall[1];
   assign frame_end = pin_rise[1];

   // ****************************************************
   // Frame sequencing.
   // ****************************************************
   nav_spi_pkg::link_state_t state_r;
   nav_spi_pkg::link_state_t state_nxt;
   logic [4:0] bit_cnt_r;
   logic last_bit;

   assign last_bit = sclk_rise && (bit_cnt_r == 5'(nav_spi_pkg::WORD_W - 1));

   // A frame cut short by deselect is dropped, so a request needs all sixteen edges.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         nav_spi_pkg::LINK_IDLE: begin
            if (frame_start) begin
               state_nxt = nav_spi_pkg::LINK_SHIFT;
            end
         end
         nav_spi_pkg::LINK_SHIFT: begin
            if (frame_end) begin
               state_nxt = nav_spi_pkg::LINK_IDLE; // [R9]
            end else if (last_bit) begin
               state_nxt = nav_spi_pkg::LINK_DECODE; // [R4] [R9]
            end
         end
         nav_spi_pkg::LINK_DECODE: begin
            state_nxt = nav_spi_pkg::LINK_IDLE;
         end
         default: begin
            state_nxt = nav_spi_pkg::LINK_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= nav_spi_pkg::LINK_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Rising edges are counted from the start of each frame.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_r <= '0;
      end else if (frame_start) begin
         bit_cnt_r <= '0;
      end else if (sclk_rise && (state_r == nav_spi_pkg::LINK_SHIFT)) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   // ****************************************************
   // Shift registers.
   // ****************************************************
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [15:0] resp_r;
   logic in_shift;

   assign in_shift = (state_r == nav_spi_pkg::LINK_SHIFT);

   // Command bits are sampled on rising serial clock edges.
   shift_word #(
      .W(nav_spi_pkg::WORD_W)
   ) u_rx (
      .clk(clk),
      .reset_n(reset_n),
      .load(frame_start),
      .load_val('0),
      .shift(sclk_rise && in_shift),
      .sin(pin_lvl[0]),
      .q(rx_q)
   );

   // The answer is loaded at select and its MSB stands through the first falling edge.
   // Only later falling edges move the next bit out, or the host would miss the MSB.
   shift_word #(
      .W(nav_spi_pkg::WORD_W)
   ) u_tx (
      .clk(clk),
      .reset_n(reset_n),
      .load(frame_start),
      .load_val(resp_r),
      .shift(sclk_fall && in_shift && (bit_cnt_r != 5'h00)), // [R2] [R3]
      .sin(1'b0),
      .q(tx_q)
   );

   // Output changes only at select and after falling edges; the pin is driven while selected.
   assign miso_o = tx_q[nav_spi_pkg::WORD_W-1]; // [R2] [R3]
   assign miso_oe = cs_active;

   // ****************************************************
   // Command decode.
   // ****************************************************
   logic cmd_write;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_data;
   logic decode;

   assign decode = (state_r == nav_spi_pkg::LINK_DECODE);
   assign cmd_write = rx_q[nav_spi_pkg::CMD_WR_BIT]; // [R8]
   assign cmd_addr = rx_q[nav_spi_pkg::CMD_ADDR_HI:nav_spi_pkg::CMD_ADDR_LO]; // [R8] [R10]
   assign cmd_data = rx_q[nav_spi_pkg::CMD_DATA_HI:0];

   // The page starts at zero; only the page register accepts writes.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_select_reg <= nav_spi_pkg::PAGE_RESET; // [R6]
      end else if (decode && cmd_write && (cmd_addr == nav_spi_pkg::ADDR_PAGE_SEL)) begin
         page_select_reg <= cmd_data; // [R7] [R17]
      end
   end

   // ****************************************************
   // Output register snapshot.
   // ****************************************************
   logic [15:0] snap_r [nav_spi_pkg::MAP_WORDS];

   // All words are taken on one strobe; signed pairs keep their high and low halves.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < nav_spi_pkg::MAP_WORDS; i++) begin
            snap_r[i] <= '0;
         end
      end else if (load_strobe) begin
         snap_r[word_idx(nav_spi_pkg::OFF_TEMP)] <= temp_raw;
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_X_LO)] <= gyro_x[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_X_HI)] <= gyro_x[2*W-1:W];
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_Y_LO)] <= gyro_y[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_Y_HI)] <= gyro_y[2*W-1:W];
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_Z_LO)] <= gyro_z[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_GYRO_Z_HI)] <= gyro_z[2*W-1:W]; // [R10]
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_X_LO)] <= accel_x[W-1:0]; // [R12]
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_X_HI)] <= accel_x[2*W-1:W]; // [R12]
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_Y_LO)] <= accel_y[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_Y_HI)] <= accel_y[2*W-1:W];
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_Z_LO)] <= accel_z[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_ACC_Z_HI)] <= accel_z[2*W-1:W];
         snap_r[word_idx(nav_spi_pkg::OFF_HEADING)] <= heading;
         snap_r[word_idx(nav_spi_pkg::OFF_PITCH)] <= pitch;
         snap_r[word_idx(nav_spi_pkg::OFF_ROLL)] <= roll;
         snap_r[word_idx(nav_spi_pkg::OFF_LAT_LO)] <= lat[W-1:0]; // [R13]
         snap_r[word_idx(nav_spi_pkg::OFF_LAT_HI)] <= lat[2*W-1:W]; // [R13]
         snap_r[word_idx(nav_spi_pkg::OFF_LON_LO)] <= lon[W-1:0];
         snap_r[word_idx(nav_spi_pkg::OFF_LON_HI)] <= lon[2*W-1:W];
         snap_r[word_idx(nav_spi_pkg::OFF_ALT)] <= alt; // [R14]
         snap_r[word_idx(nav_spi_pkg::OFF_VEL_E)] <= vel_e; // [R15]
         snap_r[word_idx(nav_spi_pkg::OFF_VEL_N)] <= vel_n; // [R15]
         snap_r[word_idx(nav_spi_pkg::OFF_VEL_U)] <= vel_u; // [R15]
         snap_r[word_idx(nav_spi_pkg::OFF_STATE)] <= state_code(nav_mode); // [R11]
      end
   end

   // ****************************************************
   // Pair shadow.
   // ****************************************************
   logic [15:0] pair_word_r;
   logic [5:0] pair_idx_r;
   logic pair_valid_r;
   logic rd_ok;
   logic [5:0] rd_idx;
   logic [15:0] rd_word;

   assign rd_idx = word_idx(cmd_addr);
   assign rd_ok = (page_select_reg == nav_spi_pkg::PAGE_RESET) && is_mapped(cmd_addr); // [R17]

   // Reading one half of a pair freezes the other half, so a fresh load
   // between the two frames cannot tear the 32-bit value.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pair_word_r <= '0;
         pair_idx_r <= '0;
         pair_valid_r <= 1'b0;
      end else if (decode) begin
         if (!cmd_write && rd_ok && is_pair(rd_idx) &&
             !(pair_valid_r && (pair_idx_r == rd_idx))) begin
            pair_word_r <= snap_r[partner(rd_idx)]; // [R18]
            pair_idx_r <= partner(rd_idx);
            pair_valid_r <= 1'b1;
         end else begin
            pair_valid_r <= 1'b0;
         end
      end
   end

   // Read multiplexer: identity, frozen partner, snapshot or zero.
   always_comb begin
      rd_word = '0;
      if (rd_ok) begin
         if (cmd_addr == nav_spi_pkg::OFF_PRODUCT_IDENTITY) begin
            rd_word = PRODUCT_IDENTITY;
         end else if (pair_valid_r && (pair_idx_r == rd_idx)) begin
            rd_word = pair_word_r; // [R18]
         end else begin
            rd_word = snap_r[rd_idx];
         end
      end
   end

   // A read answer goes out in the next frame while that frame's command
   // comes in; writes and dropped frames leave zero to shift out.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resp_r <= '0;
      end else if (decode) begin
         resp_r <= cmd_write ? '0 : rd_word; // [R4] [R5] [R8] [R9] [R17]
      end else if (frame_start) begin
         resp_r <= '0;
      end
   end

   // ****************************************************
   // Data-ready pin.
   // ****************************************************

   // A load raises the pin; the host selecting the port drops it, and a load
   // in that same cycle keeps it high.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fresh_sample_pin <= 1'b0;
      end else if (load_strobe) begin
         fresh_sample_pin <= 1'b1; // [R16]
      end else if (frame_start) begin
         fresh_sample_pin <= 1'b0;
      end
   end
endmodule : nav_spi_port

// *** nav_spi_port_chk_sva.sv ***
// Assertion checker bound to the navigation SPI register port.
`timescale 1ns/100ps
module nav_spi_port_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic load_strobe,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic fresh_sample_pin,
   input wire logic [7:0] page_select_reg
);
   // ****************************************************
   // Port properties.
   // ****************************************************
   // Every check shares the system clock and is idle during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_page_at_start: assert property (
      !$past(reset_n) |-> page_select_reg == 8'h00) else $error("page not zero after reset");
   a_page_idle_stable: assert property (
      cs_n [*4] |-> $stable(page_select_reg)) else $error("page changed outside a frame");
   a_fresh_on_load: assert property (
      load_strobe |=> fresh_sample_pin) else $error("ready not raised by load");
   a_fresh_rise_cause: assert property (
      $rose(fresh_sample_pin) |-> $past(load_strobe)) else $error("ready rose without load");
   // The ready flag must drop once a frame has started and no load intervened.
   a_fresh_clear: assert property (
      $fell(cs_n) ##1 (!load_strobe) [*6] |-> !fresh_sample_pin) else $error("ready not cleared by frame");
   a_fresh_hold: assert property (
      cs_n [*4] ##0 fresh_sample_pin |=> fresh_sample_pin) else $error("ready dropped while idle");
   a_oe_off_idle: assert property (
      cs_n [*4] |-> !miso_oe) else $error("output driven while deselected");
   a_oe_on_select: assert property (
      !cs_n [*4] |-> miso_oe) else $error("output not driven while selected");
   // A long high clock phase inside a frame may never move the output bit.
   a_miso_high_stable: assert property (
      (!cs_n && sclk) [*6] |-> $stable(miso_o)) else $error("output moved while clock high");
endmodule : nav_spi_port_chk

bind nav_spi_port nav_spi_port_chk chk (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
   .load_strobe(load_strobe), .miso_o(miso_o), .miso_oe(miso_oe), .fresh_sample_pin(fresh_sample_pin),
   .page_select_reg(page_select_reg));

// *** nav_host_model.sv ***
// Behavioural host processor acting as the serial master of the register port.
`timescale 1ns/100ps
module nav_host_model #(
   parameter int HALF = 5
) (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe
);
   // ****************************************************
   // Line levels and frame task.
   // ****************************************************
   // An undriven output line shows the inverse so a stale bit never passes.
   wire miso = miso_oe ? miso_o : ~miso_o;
   // Clock edges per frame; a smaller count gives a frame that deselect cuts short.
   int nbits = 16;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One frame of nbits clocks: five system clocks per half period keeps the rate at 5 MHz.
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      int i;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (8) @(negedge clk);
      for (i = 15; i >= 16 - nbits; i--) begin
         sclk = 1'b0;
         mosi = tx[i];
         repeat (HALF) @(negedge clk);
         rx[i] = miso;
         sclk = 1'b1;
         repeat (HALF) @(negedge clk);
      end
      repeat (3) @(negedge clk);
      cs_n = 1'b1;
      mosi = ~mosi;
      repeat (6) @(negedge clk);
   endtask : xfer
endmodule : nav_host_model

// *** nav_spi_port_tb.sv ***
// Self-checking testbench for the navigation SPI register port.
`timescale 1ns/100ps
module nav_spi_port_tb;
   localparam logic [15:0] ID_VAL = 16'h2b6d; // Arbitrary identity value.
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic load_strobe = 1'b0;
   logic sclk, cs_n, mosi, miso_o, miso_oe, fresh_sample_pin;
   logic [7:0] page_select_reg, kk, pg;
   logic [15:0] temp_raw, heading, pitch, roll, alt, vel_e, vel_n, vel_u, exp_q, rx;
   logic [31:0] gyro_x, gyro_y, gyro_z, accel_x, accel_y, accel_z, lat, lon;
   logic [1:0] nav_mode;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int i;
   // ****************************************************
   // Clock, design and host.
   // ****************************************************
   always #10 clk = ~clk;
   nav_spi_port #(.PRODUCT_IDENTITY(ID_VAL)) uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .fresh_sample_pin(fresh_sample_pin),
      .page_select_reg(page_select_reg), .load_strobe(load_strobe), .temp_raw(temp_raw),
      .gyro_x(gyro_x), .gyro_y(gyro_y), .gyro_z(gyro_z), .accel_x(accel_x), .accel_y(accel_y),
      .accel_z(accel_z), .heading(heading), .pitch(pitch), .roll(roll), .lat(lat), .lon(lon),
      .alt(alt), .vel_e(vel_e), .vel_n(vel_n), .vel_u(vel_u), .nav_mode(nav_mode));
   nav_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
      .miso_oe(miso_oe));
   // ****************************************************
   // Helpers.
   // ****************************************************
   // Every data word is {stamp, byte address}, so swapped halves or wrong offsets show at once.
   function automatic logic [15:0] expv(input logic [15:0] w);
      logic [6:0] a;
      a = w[14:8];
      if (w[15] || pg != 8'h00) return 16'h0000;
      if (!a[0] && ((a >= 7'h0e && a <= 7'h26) || (a >= 7'h60 && a <= 7'h74))) return {kk, 1'b0, a};
      if (a == 7'h76) return {10'h000, nav_mode, 4'h0};
      if (a == 7'h7e) return ID_VAL;
      return 16'h0000;
   endfunction : expv
   task setv(input logic [7:0] k, input logic [1:0] m);
      kk = k;
      nav_mode = m;
      temp_raw = {k, 8'h0e};
      gyro_x = {k, 8'h12, k, 8'h10};
      gyro_y = {k, 8'h16, k, 8'h14};
      gyro_z = {k, 8'h1a, k, 8'h18};
      accel_x = {k, 8'h1e, k, 8'h1c};
      accel_y = {k, 8'h22, k, 8'h20};
      accel_z = {k, 8'h26, k, 8'h24};
      heading = {k, 8'h60};
      pitch = {k, 8'h62};
      roll = {k, 8'h64};
      lat = {k, 8'h68, k, 8'h66};
      lon = {k, 8'h6c, k, 8'h6a};
      alt = {k, 8'h6e};
      vel_e = {k, 8'h70};
      vel_n = {k, 8'h72};
      vel_u = {k, 8'h74};
   endtask : setv
   // One load pulse, then wait until the ready flag had its edge to rise.
   task ld(input logic [7:0] k, input logic [1:0] m);
      @(negedge clk);
      setv(k, m);
      load_strobe = 1'b1;
      @(negedge clk);
      load_strobe = 1'b0;
      repeat (2) @(negedge clk);
   endtask : ld
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Send a command; the answer seen belongs to the command before it.
   task cmd(input logic [15:0] w);
      host.xfer(w, rx);
      chk($sformatf("answer during command %h", w), exp_q, rx);
      exp_q = expv(w);
      if (w[15:8] == 8'h80) pg = w[7:0];
   endtask : cmd
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // A hung handshake ends the run as a failure.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         summarize();
      end
   end
   // ****************************************************
   // Test sequence.
   // ****************************************************
   initial begin
      setv(8'h00, 2'd0);
      pg = 8'h00;
      exp_q = 16'h0000;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("page after reset", 16'h0000, {8'h00, page_select_reg});
      chk("ready after reset", 16'h0000, {15'h0000, fresh_sample_pin});
      $display("test reset done, mismatches %0d", fails);
      ld(8'hc3, 2'd1);
      chk("ready after load", 16'h0001, {15'h0000, fresh_sample_pin});
      for (i = 14; i <= 126; i += 2) cmd(16'(i << 8));
      cmd(16'h1aff);
      cmd(16'h1800);
      cmd(16'h1100);
      chk("ready after frames", 16'h0000, {15'h0000, fresh_sample_pin});
      $display("test map done, mismatches %0d", fails);
      for (i = 0; i < 4; i++) begin
         ld(8'h3c, i[1:0]);
         cmd(16'h7600);
      end
      $display("test state done, mismatches %0d", fails);
      ld(8'ha5, 2'd3);
      cmd(16'h1a00);
      ld(8'h5a, 2'd3);
      cmd(16'h1800);
      exp_q = 16'ha518;
      cmd(16'h6800);
      cmd(16'h6600);
      $display("test snapshot done, mismatches %0d", fails);
      cmd(16'h8001);
      chk("page after write", 16'h0001, {8'h00, page_select_reg});
      cmd(16'h1a00);
      cmd(16'h7e00);
      cmd(16'h8000);
      chk("page after return", 16'h0000, {8'h00, page_select_reg});
      cmd(16'h9a55);
      cmd(16'h7e00);
      cmd(16'h1a00);
      host.nbits = 8;
      host.xfer(16'h7e00, rx);
      host.nbits = 16;
      exp_q = 16'h0000;
      cmd(16'h0000);
      chk("page after ignored write", 16'h0000, {8'h00, page_select_reg});
      $display("test page done, mismatches %0d", fails);
      summarize();
   end
endmodule : nav_spi_port_tb
